//--- twm_pkg.sv
// constants for the two-wire master transmitter
// assumes one 40 MHz core clock and an open-drain bus outside
package twm_pkg;
	// ----------------------------------------
	// register indices
	// ----------------------------------------
	localparam logic [1:0] ADDR_CTRL = 2'h0;
	localparam logic [1:0] ADDR_STAT = 2'h1;
	localparam logic [1:0] ADDR_DATA = 2'h2;
	// ----------------------------------------
	// control field positions
	// ----------------------------------------
	localparam int CB_FLAG = 7;
	localparam int CB_ACK = 6;
	localparam int CB_STA = 5;
	localparam int CB_STO = 4;
	localparam int CB_EN = 2;
	localparam int CB_IE = 0;
	// ----------------------------------------
	// reset values and masks
	// ----------------------------------------
	localparam logic [7:0] DATA_RST = 8'hFF;
	localparam logic [1:0] PRESC_RST = 2'h0;
	localparam logic [7:0] CODE_MASK = 8'hF8;
	// ----------------------------------------
	// status codes
	// ----------------------------------------
	localparam logic [7:0] SC_START = 8'h08;
	localparam logic [7:0] SC_RSTART = 8'h10;
	localparam logic [7:0] SC_AW_ACK = 8'h18;
	localparam logic [7:0] SC_AW_NACK = 8'h20;
	localparam logic [7:0] SC_D_ACK = 8'h28;
	localparam logic [7:0] SC_D_NACK = 8'h30;
	localparam logic [7:0] SC_ARB = 8'h38;
	localparam logic [7:0] SC_AR_ACK = 8'h40;
	localparam logic [7:0] SC_AR_NACK = 8'h48;
	localparam logic [7:0] SC_NONE = 8'hF8;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_NS = 25;
	localparam int QTR_NS = 2500;
	localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);
	localparam logic [3:0] BIT_ACK = 4'h8;
	typedef enum logic [2:0] {
		S_IDLE, S_WAIT_FREE, S_START, S_BYTE, S_STOP, S_HOLD
	} twm_state_t;
endpackage

//--- twm_master.sv
// two-wire master transmitter with control, status and data registers
// assumes open-drain scl/sda resolved outside, plain register port
//
// Behaviour
// - flag, stop, enable written: stop goes out
// - flag, start, enable written: restart goes out
// - restart reports 0x10, no stop needed
// - restart keeps bus ownership across modes
// - at 0x08 load address, clear flag: send
// - at 0x10 read address enters receiver mode
// - write address ack gives 0x18, nack 0x20; read address 0x40, 0x48
// - data ack gives 0x28, nack 0x30
// - ack states: load byte, clear flag, send
// - ack states: start without load sends restart
// - stop request sends stop, hardware clears it
// - stop plus start: stop then start
// - lost arbitration reports 0x38
// - 0x38 without start releases bus
// - 0x38 with start waits free, starts
// - master mode only after a start
// - first address direction bit selects mode
// - status reads code masked to bits 7:3, prescaler in bits 1:0
// - data write with flag low: discarded, collision
// - transfer held while flag set
// - start waits bus free, then 0x08
`timescale 1ns/1ps
`default_nettype none
module twm_master
	import twm_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic master_rx_o,
	output logic irq_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	twm_state_t state, next_state;
	logic [1:0] ph, next_ph;
	logic [3:0] bc, next_bc;
	logic next_sda_oe, next_scl_oe;
	logic [6:0] cnt;
	logic flag, ack_en, start_request_column, stop_request_column, wcol, en, ie;
	logic [7:0] code, data, shreg;
	logic [1:0] presc;
	logic owner, is_addr, dir, got_ack, bus_busy, pin_lo;
	logic sda_m, sda_s, sda_d, scl_m, scl_s;
	logic ev_start, ev_byte, ev_arb, ev_stop, ev_rel, ev_load;
	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire wr_ctrl = wr_i && addr_i == ADDR_CTRL;
	wire wr_stat = wr_i && addr_i == ADDR_STAT;
	wire wr_data = wr_i && addr_i == ADDR_DATA;
	wire resume = wr_ctrl && wdata_i[CB_FLAG] && flag;
	wire wsta = wdata_i[CB_STA];
	wire wsto = wdata_i[CB_STO];
	wire tick = cnt == QTR_LAST;
	wire last_bit = bc == BIT_ACK;
	wire arb_hit = !last_bit && shreg[7] && !sda_s;
	wire step = tick && (ph != 2'h2 || scl_s);
	wire start_seen = scl_s && sda_d && !sda_s;
	wire stop_seen = scl_s && !sda_d && sda_s;
	wire set_flag = ev_start || ev_byte || ev_arb;
	wire next_flag = set_flag || (flag && !resume);
	wire [7:0] ctrl_val = {flag, ack_en, start_request_column, stop_request_column, wcol, en, 1'b0, ie};
	wire [7:0] stat_val = (code & CODE_MASK) | {6'h00, presc};
	wire [7:0] rd_val = addr_i == ADDR_CTRL ? ctrl_val :
		addr_i == ADDR_STAT ? stat_val :
		addr_i == ADDR_DATA ? data : 8'h00;
	wire [7:0] addr_code = dir ? (got_ack ? SC_AR_ACK : SC_AR_NACK) :
		(got_ack ? SC_AW_ACK : SC_AW_NACK);
	wire [7:0] data_code = got_ack ? SC_D_ACK : SC_D_NACK;
	wire [7:0] start_code = owner ? SC_RSTART : SC_START;
	// ----------------------------------------
	// pin sampling and bus-free tracking
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			{sda_m, sda_s, sda_d, scl_m, scl_s} <= 5'h1F;
			bus_busy <= 1'b0;
			cnt <= 7'h00;
			pin_lo <= 1'b0;
		end else begin
			sda_m <= sda_i;
			sda_s <= sda_m;
			sda_d <= sda_s;
			scl_m <= scl_i;
			scl_s <= scl_m;
			cnt <= tick ? 7'h00 : cnt + 7'h01;
			pin_lo <= 1'b0;
			if (start_seen)
				bus_busy <= 1'b1;
			else if (stop_seen)
				bus_busy <= 1'b0;
		end
	end
	// ----------------------------------------
	// bit engine
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_ph = ph;
		next_bc = bc;
		next_sda_oe = sda_oe_o;
		next_scl_oe = scl_oe_o;
		ev_start = 1'b0;
		ev_byte = 1'b0;
		ev_arb = 1'b0;
		ev_stop = 1'b0;
		ev_rel = 1'b0;
		ev_load = 1'b0;
		if (!en) begin
			next_state = S_IDLE;
			next_sda_oe = 1'b0;
			next_scl_oe = 1'b0;
		end else begin
			unique case (state)
			S_IDLE: if (start_request_column && !flag) next_state = S_WAIT_FREE;
			S_WAIT_FREE: if (tick && !bus_busy) begin
				next_state = S_START;
				next_ph = 2'h0;
			end
			S_START: if (step) begin
				next_ph = ph + 2'h1;
				unique case (ph)
				2'h0: next_sda_oe = 1'b0;
				2'h1: next_scl_oe = 1'b0;
				2'h2: next_sda_oe = 1'b1;
				2'h3: begin
					next_scl_oe = 1'b1;
					ev_start = 1'b1;
					next_state = S_HOLD;
				end
				endcase
			end
			S_BYTE: if (step) begin
				next_ph = ph + 2'h1;
				unique case (ph)
				2'h0: next_sda_oe = !last_bit && !shreg[7];
				2'h1: next_scl_oe = 1'b0;
				2'h2: if (arb_hit) begin
					ev_arb = 1'b1;
					next_sda_oe = 1'b0;
					next_scl_oe = 1'b0;
					next_state = S_HOLD;
				end
				2'h3: begin
					next_scl_oe = 1'b1;
					if (last_bit) begin
						ev_byte = 1'b1;
						next_state = S_HOLD;
					end else begin
						next_bc = bc + 4'h1;
					end
				end
				endcase
			end
			S_STOP: if (step) begin
				next_ph = ph + 2'h1;
				if (ph == 2'h0) begin
					next_sda_oe = 1'b1;
				end else if (ph == 2'h1) begin
					next_scl_oe = 1'b0;
				end else begin
					next_sda_oe = 1'b0;
					ev_stop = 1'b1;
					next_state = start_request_column ? S_WAIT_FREE : S_IDLE;
				end
			end
			S_HOLD: if (resume) begin
				next_ph = 2'h0;
				next_bc = 4'h0;
				if (!owner) begin
					next_state = wsta ? S_WAIT_FREE : S_IDLE;
					ev_rel = !wsta;
				end else if (wsto) begin
					next_state = S_STOP;
				end else if (wsta) begin
					next_state = S_START;
				end else begin
					next_state = S_BYTE;
					ev_load = 1'b1;
				end
			end
			endcase
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state <= S_IDLE;
			ph <= 2'h0;
			bc <= 4'h0;
			sda_oe_o <= 1'b0;
			scl_oe_o <= 1'b0;
		end else begin
			state <= next_state;
			ph <= next_ph;
			bc <= next_bc;
			sda_oe_o <= next_sda_oe;
			scl_oe_o <= next_scl_oe;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			shreg <= 8'h00;
			got_ack <= 1'b0;
		end else if (ev_load) begin
			shreg <= data;
		end else if (state == S_BYTE && step && ph == 2'h3 && !last_bit) begin
			shreg <= {shreg[6:0], 1'b0};
		end else if (state == S_BYTE && step && ph == 2'h2 && last_bit) begin
			got_ack <= !sda_s;
		end
	end
	// ----------------------------------------
	// status and ownership
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			code <= SC_NONE;
			owner <= 1'b0;
			is_addr <= 1'b0;
			dir <= 1'b0;
			master_rx_o <= 1'b0;
		end else if (ev_start) begin
			code <= start_code;
			owner <= 1'b1;
			is_addr <= 1'b1;
		end else if (ev_byte) begin
			code <= is_addr ? addr_code : data_code;
			is_addr <= 1'b0;
			if (is_addr)
				master_rx_o <= dir;
		end else if (ev_arb) begin
			code <= SC_ARB;
			owner <= 1'b0;
			master_rx_o <= 1'b0;
		end else if (ev_stop || ev_rel || !en) begin
			code <= SC_NONE;
			owner <= 1'b0;
			master_rx_o <= 1'b0;
		end else if (ev_load && is_addr) begin
			dir <= data[0];
		end
	end
	// ----------------------------------------
	// register file
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			{flag, ack_en, start_request_column, stop_request_column, wcol, en, ie} <= 7'h00;
			data <= DATA_RST;
			presc <= PRESC_RST;
			rdata_o <= 8'h00;
			irq_o <= 1'b0;
		end else begin
			flag <= next_flag;
			irq_o <= flag && ie;
			rdata_o <= rd_i ? rd_val : 8'h00;
			if (wr_ctrl) begin
				{ack_en, start_request_column, en, ie} <= {wdata_i[CB_ACK], wsta, wdata_i[CB_EN], wdata_i[CB_IE]};
				stop_request_column <= wsto;
			end else if (ev_stop) begin
				stop_request_column <= 1'b0;
			end
			if (wr_stat)
				presc <= wdata_i[1:0];
			if (wr_data) begin
				wcol <= !flag;
				if (flag)
					data <= wdata_i;
			end
		end
	end
	assign scl_o = pin_lo;
	assign sda_o = pin_lo;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_wcol_on_late: assert property (wr_data && !flag |=> wcol)
		else $error("collision bit not set");
	a_data_discard: assert property (wr_data && !flag && !ev_load |=> $stable(data))
		else $error("late data write stored");
	a_hold_pins: assert property (flag && $past(flag) |-> $stable(scl_oe_o) && $stable(sda_oe_o))
		else $error("bus moved while suspended");
	a_start_code: assert property (ev_start |=> flag && code == $past(start_code) && owner)
		else $error("wrong start status");
	a_addr_code: assert property (ev_byte && is_addr && !dir |=> code == (got_ack ? 8'h18 : 8'h20))
		else $error("wrong address status");
	a_data_code: assert property (ev_byte && !is_addr |=> code == (got_ack ? 8'h28 : 8'h30))
		else $error("wrong data status");
	a_arb_code: assert property (ev_arb |=> code == 8'h38 && flag && !sda_oe_o && !scl_oe_o)
		else $error("arbitration loss not reported");
	a_stop_clear: assert property (ev_stop && !wr_ctrl |=> !stop_request_column && !flag)
		else $error("stop request not cleared");
	a_release_bus: assert property (resume && state == S_HOLD && !owner && !wsta |=> ##[0:1] state == S_IDLE && !sda_oe_o)
		else $error("bus not released");
	a_irq_follow: assert property (flag && ie |=> irq_o)
		else $error("interrupt missing");
	// ----------------------------------------
	// checks: sequencing and ownership
	// ----------------------------------------
	a_rstart_code: assert property (
		ev_start && owner |=> code == SC_RSTART && flag)
		else $error("wrong restart status");
	a_rstart_keep: assert property (
		state == S_HOLD && resume && owner && wsta && !wsto && en |=> state == S_START && owner)
		else $error("restart not taken");
	a_owner_kept: assert property (
		owner && state == S_START && en |=> owner)
		else $error("ownership lost in restart");
	a_load_shreg: assert property (
		ev_load |=> shreg == $past(data) && state == S_BYTE)
		else $error("byte not loaded");
	a_rx_switch: assert property (
		ev_byte && is_addr |=> master_rx_o == $past(dir))
		else $error("mode not taken from direction");
	a_stop_enter: assert property (
		state == S_HOLD && resume && owner && wsto && en |=> state == S_STOP)
		else $error("stop not started");
	a_stop_restart: assert property (
		ev_stop && start_request_column |=> state == S_WAIT_FREE)
		else $error("start after stop missing");
	a_arb_retry: assert property (
		state == S_HOLD && resume && !owner && wsta && en |=> state == S_WAIT_FREE)
		else $error("start after lost arbitration missing");
	a_release_pins: assert property (
		ev_rel |=> !scl_oe_o && !sda_oe_o && code == SC_NONE)
		else $error("bus not left");
	a_master_start: assert property (
		$rose(owner) |-> $past(ev_start))
		else $error("ownership without start");
	a_idle_stays: assert property (
		state == S_IDLE && en && !start_request_column |=> state == S_IDLE)
		else $error("left idle without start");
	a_status_mask: assert property (
		stat_val[2:0] == {1'b0, presc} && stat_val[7:3] == code[7:3])
		else $error("status layout wrong");
	a_wait_busy: assert property (
		state == S_WAIT_FREE && bus_busy && en |=> state == S_WAIT_FREE)
		else $error("start on busy bus");
	// ----------------------------------------
	// checks: suspension and data register
	// ----------------------------------------
	a_suspend_state: assert property (
		state == S_HOLD && !resume && en |=> state == S_HOLD)
		else $error("transfer resumed without clear");
	a_scl_held: assert property (
		state == S_HOLD && owner |-> scl_oe_o)
		else $error("clock not held while suspended");
	a_byte_flag: assert property (
		ev_byte |=> flag && state == S_HOLD)
		else $error("flag not set after byte");
	a_data_store: assert property (
		wr_data && flag |=> !wcol && data == $past(wdata_i))
		else $error("data write lost");
endmodule
`default_nettype wire

//--- twm_slave_model.sv
// slave receiver on the two-wire bus, able to spoil arbitration
// assumes open-drain wires resolved in the bench with pull-ups
`timescale 1ns/1ps
`default_nettype none
module twm_slave_model
	import twm_pkg::*;
#(
	parameter logic [6:0] SLV_ADDR = 7'h50
)
(
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic nack_i,
	input wire logic arb_i,
	output logic sda_pull_o,
	output logic [7:0] rx_byte_o
);
	logic [3:0] cnt = 4'h0;
	logic first = 1'b0;
	logic ack_pull = 1'b0;
	initial rx_byte_o = 8'h00;
	// competing master holds sda low through the address packet
	assign sda_pull_o = ack_pull | (arb_i & first);
	always @(negedge sda_i) if (scl_i) begin
		cnt = 4'h0;
		first = 1'b1;
	end
	always @(posedge scl_i) begin
		if (cnt < 4'h8) rx_byte_o = {rx_byte_o[6:0], sda_i};
		cnt = cnt + 4'h1;
	end
	always @(negedge scl_i) begin
		if (cnt == 4'h8) ack_pull = first ? (rx_byte_o[7:1] == SLV_ADDR) : !nack_i;
		if (cnt == 4'h9) begin
			ack_pull = 1'b0;
			cnt = 4'h0;
			first = 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- tb_twm_master.sv
// self-checking bench for the two-wire master transmitter
// assumes the slave model on open-drain wires with pull-ups
`timescale 1ns/1ps
`default_nettype none
module tb_twm_master
	import twm_pkg::*;
;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [1:0] addr_i = 2'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic nack = 1'b0;
	logic arb = 1'b0;
	logic [7:0] rdata_o, rx_byte;
	logic scl_o, scl_oe_o, sda_o, sda_oe_o, master_rx_o, irq_o, sda_pull;
	wire scl_w = !scl_oe_o;
	wire sda_w = !(sda_oe_o || sda_pull);
	int fails = 0;
	int cmp_count = 0;
	always #12.5 core_clk_i = !core_clk_i;
	twm_master twm_master_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_w),
		.scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .master_rx_o(master_rx_o), .irq_o(irq_o));
	twm_slave_model twm_slave_model_inst (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack),
		.arb_i(arb), .sda_pull_o(sda_pull), .rx_byte_o(rx_byte));
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
			fails++;
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		@(posedge core_clk_i);
	endtask
	task automatic rdchk(input logic [1:0] a, input logic [7:0] exp, input string nm);
		logic [7:0] v;
		rd(a, v);
		chk(nm, v, exp);
	endtask
	task automatic wait_bit(input int b, input logic lvl);
		logic [7:0] v;
		for (int n = 0; n < 6000; n++) begin
			rd(ADDR_CTRL, v);
			if (v[b] === lvl) break;
		end
		chk("ctrl bit wait", {7'h0, v[b]}, {7'h0, lvl});
	endtask
	task automatic go(input logic [7:0] d, input logic [7:0] ctl, input logic [7:0] code);
		logic [7:0] v;
		if (ctl[CB_STA] == 1'b0) wr(ADDR_DATA, d);
		wr(ADDR_CTRL, ctl);
		wait_bit(CB_FLAG, 1'b1);
		rd(ADDR_STAT, v);
		chk("status", v, code);
		chk("status masked", v & CODE_MASK, code);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdchk(ADDR_CTRL, 8'h00, "ctrl");
		rdchk(ADDR_STAT, SC_NONE, "status");
		rdchk(ADDR_DATA, DATA_RST, "data");
		rdchk(2'h3, 8'h00, "unmapped");
		chk("pin low values", {6'h0, sda_o, scl_o}, 8'h00);
		wr(ADDR_DATA, 8'h55);
		rdchk(ADDR_CTRL, 8'h08, "collision");
		rdchk(ADDR_DATA, DATA_RST, "data kept");
	endtask
	task automatic t_send();
		go(8'h00, 8'hA5, SC_START);
		chk("irq", {7'h0, irq_o}, 8'h01);
		chk("scl held", {7'h0, scl_oe_o}, 8'h01);
		go(8'hA0, 8'h85, SC_AW_ACK);
		chk("rx mode", {7'h0, master_rx_o}, 8'h00);
		go(8'h55, 8'h85, SC_D_ACK);
		chk("wire byte", rx_byte, 8'h55);
		nack <= 1'b1;
		go(8'hAA, 8'h85, SC_D_NACK);
		nack <= 1'b0;
		chk("pin low values", {6'h0, sda_o, scl_o}, 8'h00);
	endtask
	task automatic t_restart();
		go(8'h00, 8'hA5, SC_RSTART);
		chk("scl owned", {7'h0, scl_oe_o}, 8'h01);
		go(8'hC0, 8'h85, SC_AW_NACK);
		go(8'h00, 8'hA5, SC_RSTART);
		go(8'hA1, 8'h85, SC_AR_ACK);
		chk("rx mode", {7'h0, master_rx_o}, 8'h01);
		wr(ADDR_CTRL, 8'h95);
		wait_bit(CB_STO, 1'b0);
		repeat (400) @(posedge core_clk_i);
		chk("released", {6'h0, sda_w, scl_w}, 8'h03);
		rdchk(ADDR_STAT, SC_NONE, "status idle");
	endtask
	task automatic t_stop_start();
		go(8'h00, 8'hA5, SC_START);
		go(8'hA0, 8'h85, SC_AW_ACK);
		go(8'h00, 8'hB5, SC_START);
		rdchk(ADDR_CTRL, 8'hA5, "stop cleared");
	endtask
	task automatic t_arb();
		arb <= 1'b1;
		go(8'hA0, 8'h85, SC_ARB);
		arb <= 1'b0;
		wr(ADDR_CTRL, 8'h85);
		repeat (20) @(posedge core_clk_i);
		rdchk(ADDR_STAT, SC_NONE, "status idle");
		chk("released", {6'h0, sda_oe_o, scl_oe_o}, 8'h00);
		go(8'h00, 8'hA5, SC_START);
		arb <= 1'b1;
		go(8'hA0, 8'h85, SC_ARB);
		arb <= 1'b0;
		go(8'h00, 8'hA5, SC_START);
	endtask
	task automatic results();
		if (fails == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(posedge core_clk_i);
		t_reset();
		t_send();
		t_restart();
		t_stop_start();
		t_arb();
		results();
	end
	initial begin
		repeat (90000) @(posedge core_clk_i);
		fails++;
		results();
	end
endmodule
`default_nettype wire
